// file: pkg/dcc_pkg.sv
// Contract
// - view select picks comparator read register
// - comparator control writes blocked while unit armed
// - bit 7 enables size check unless tagging
// - bit 6 chooses word zero byte one
// - size bits exist on comparators a, b only
// - tag clear: match advances sequencer immediately
// - tag set: trigger when tagged opcode executes
// - bit 4 match ends session, disarms unit
// - bit 4 clear: sequencer alone ends session
// - immediate breakpoint needs unit breakpoint enable
// - bit 2 enables direction check unless tagging
// - bit 3 chooses write zero read one
// - comparator a bit 1 selects data mismatch
// - data mismatch select only on comparator a
// - bit 0 enables comparator, else never matches
package dcc_pkg;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [11:0] ADDR_COMP_CTRL = 12'h000;
    localparam logic [11:0] ADDR_UNIT_CTRL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_INT_ENABLE = 12'h00C;
    localparam logic [11:0] ADDR_INT_CLEAR = 12'h010;
    localparam logic [11:0] ADDR_COMP_DATA_A = 12'h014;

    // =====================================================================
    // comparator control fields
    localparam int BIT_SIZE_EN = 7;
    localparam int BIT_SIZE_VAL = 6;
    localparam int BIT_TAG = 5;
    localparam int BIT_SESSION_END = 4;
    localparam int BIT_DIR_VAL = 3;
    localparam int BIT_DIR_EN = 2;
    localparam int BIT_MISMATCH = 1;
    localparam int BIT_COMP_EN = 0;
    localparam logic [7:0] MASK_COMP_A = 8'hFF;
    localparam logic [7:0] MASK_COMP_B = 8'hFD;
    localparam logic [7:0] MASK_COMP_C = 8'h3D;
    localparam logic [7:0] RESET_COMP_CTRL = 8'h00;

    // =====================================================================
    // unit control fields: [1:0] view select, [4] breakpoint enable, [7] arm
    localparam int BIT_VIEW_LO = 0;
    localparam int BIT_BRK_EN = 4;
    localparam int BIT_ARM = 7;
    localparam logic [1:0] VIEW_A = 2'h0;
    localparam logic [1:0] VIEW_B = 2'h1;
    localparam logic [1:0] VIEW_C = 2'h2;

    // =====================================================================
    // status / interrupt bits
    localparam int ST_MATCH_A = 0;
    localparam int ST_MATCH_B = 1;
    localparam int ST_MATCH_C = 2;
    localparam int ST_SESSION_END = 3;
    localparam int ST_WIDTH = 4;

    // monitored cpu bus access
    typedef struct packed {
        logic valid;
        logic read;
        logic byte_size;
        logic [15:0] data;
        logic [2:0] addr_hit;
    } dcc_access_t;

endpackage

// file: hdl/dcc_top.sv
`timescale 1ns/10ps
module dcc_top (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // monitored bus and instruction queue
    input wire dcc_pkg::dcc_access_t access,
    input wire logic [2:0] tag_exec,
    input wire logic seq_session_end,
    // debug outputs
    output logic [2:0] seq_trigger,
    output logic [2:0] opcode_tag,
    output logic breakpoint,
    output logic trace_stop,
    output logic armed,
    output logic irq
);

    // =====================================================================
    // state
    logic [7:0] ctrl [3];
    logic [7:0] unit_ctrl;
    logic [15:0] data_a;
    logic [dcc_pkg::ST_WIDTH-1:0] status;
    logic [dcc_pkg::ST_WIDTH-1:0] int_en;
    logic [2:0] match;
    logic [2:0] imm_end;
    logic session_end;
    logic wr;
    logic [1:0] view;
    logic [7:0] comp_mask [3];

    assign comp_mask[0] = dcc_pkg::MASK_COMP_A;
    assign comp_mask[1] = dcc_pkg::MASK_COMP_B;
    assign comp_mask[2] = dcc_pkg::MASK_COMP_C;
    assign wr = psel && penable && pwrite;
    assign view = unit_ctrl[dcc_pkg::BIT_VIEW_LO +: 2];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign armed = unit_ctrl[dcc_pkg::BIT_ARM];

    // =====================================================================
    // match qualification
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic [7:0] c;
            logic ok;
            c = ctrl[i];
            ok = access.valid && access.addr_hit[i];
            if (!c[dcc_pkg::BIT_TAG]) begin
                if (c[dcc_pkg::BIT_SIZE_EN] &&
                    (c[dcc_pkg::BIT_SIZE_VAL] != access.byte_size)) begin
                    ok = 1'b0;
                end
                if (c[dcc_pkg::BIT_DIR_EN] &&
                    (c[dcc_pkg::BIT_DIR_VAL] != access.read)) begin
                    ok = 1'b0;
                end
                if (i == 0) begin
                    if (c[dcc_pkg::BIT_MISMATCH] == (access.data == data_a)) begin
                        ok = 1'b0;
                    end
                end
            end
            match[i] = ok && c[dcc_pkg::BIT_COMP_EN];
        end
    end

    // =====================================================================
    // sequencer triggers, tagging, session end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            seq_trigger[i] = ctrl[i][dcc_pkg::BIT_TAG]
                ? (tag_exec[i] && ctrl[i][dcc_pkg::BIT_COMP_EN])
                : match[i];
            opcode_tag[i] = match[i] && ctrl[i][dcc_pkg::BIT_TAG];
            imm_end[i] = armed && seq_trigger[i] && ctrl[i][dcc_pkg::BIT_SESSION_END];
        end
    end
    assign session_end = armed && ((|imm_end) || seq_session_end);
    assign breakpoint = session_end && unit_ctrl[dcc_pkg::BIT_BRK_EN];
    assign trace_stop = session_end;

    // =====================================================================
    // comparator control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                ctrl[i] <= dcc_pkg::RESET_COMP_CTRL;
            end
        end else if (wr && paddr == dcc_pkg::ADDR_COMP_CTRL && !armed) begin
            for (int i = 0; i < 3; i++) begin
                if (view == 2'(i)) begin
                    ctrl[i] <= pwdata[7:0] & comp_mask[i];
                end
            end
        end
    end

    // =====================================================================
    // unit control, data value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_ctrl <= 8'h00;
        end else if (session_end) begin
            unit_ctrl[dcc_pkg::BIT_ARM] <= 1'b0;
        end else if (wr && paddr == dcc_pkg::ADDR_UNIT_CTRL) begin
            unit_ctrl <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_a <= 16'h0000;
        end else if (wr && paddr == dcc_pkg::ADDR_COMP_DATA_A && !armed) begin
            data_a <= pwdata[15:0];
        end
    end

    // =====================================================================
    // interrupts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en <= '0;
        end else if (wr && paddr == dcc_pkg::ADDR_INT_ENABLE) begin
            int_en <= pwdata[dcc_pkg::ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            // set wins over clear
            status <= (status & ~((wr && paddr == dcc_pkg::ADDR_INT_CLEAR)
                      ? pwdata[dcc_pkg::ST_WIDTH-1:0] : '0))
                      | {session_end, seq_trigger};
        end
    end
    assign irq = |(status & int_en);

    // =====================================================================
    // read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                dcc_pkg::ADDR_COMP_CTRL: begin
                    case (view)
                        dcc_pkg::VIEW_A: prdata <= {24'h0, ctrl[0]};
                        dcc_pkg::VIEW_B: prdata <= {24'h0, ctrl[1]};
                        dcc_pkg::VIEW_C: prdata <= {24'h0, ctrl[2]};
                        default: prdata <= 32'h0;
                    endcase
                end
                dcc_pkg::ADDR_UNIT_CTRL: prdata <= {24'h0, unit_ctrl};
                dcc_pkg::ADDR_STATUS: prdata <= {28'h0, status};
                dcc_pkg::ADDR_INT_ENABLE: prdata <= {28'h0, int_en};
                dcc_pkg::ADDR_COMP_DATA_A: prdata <= {16'h0, data_a};
                default: prdata <= 32'h0;
            endcase
        end
    end

endmodule // dcc_top

// file: sim/dcc_props.sv
`timescale 1ns/10ps
// ================
// match and session end checks
module dcc_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // watched
    input wire dcc_pkg::dcc_access_t access,
    input wire logic [2:0] tag_exec,
    input wire logic seq_session_end,
    input wire logic [2:0] seq_trigger,
    input wire logic [2:0] opcode_tag,
    input wire logic breakpoint,
    input wire logic trace_stop,
    input wire logic armed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    trig_src_a: assert property (seq_trigger[0] |-> access.addr_hit[0] || tag_exec[0])
        else $error("trigger a without cause");
    ctrig_src_a: assert property (seq_trigger[2] |-> access.addr_hit[2] || tag_exec[2])
        else $error("trigger c without cause");
    tag_src_a: assert property (opcode_tag[1] |-> access.valid && access.addr_hit[1])
        else $error("tag b without hit");
    brk_armed_a: assert property (breakpoint |-> armed && trace_stop)
        else $error("breakpoint while idle");
    brk_disarm_a: assert property (breakpoint |=> !armed)
        else $error("no disarm after breakpoint");
    stop_disarm_a: assert property (trace_stop |=> !armed)
        else $error("no disarm after stop");
    seq_end_a: assert property (armed && seq_session_end |-> trace_stop ##1 !armed)
        else $error("sequencer end ignored");
    idle_quiet_a: assert property (!armed |-> !breakpoint && !trace_stop)
        else $error("session end while idle");
endmodule // dcc_props
bind dcc_top dcc_props dcc_props_inst (.pclk, .presetn, .access, .tag_exec, .seq_session_end,
    .seq_trigger, .opcode_tag, .breakpoint, .trace_stop, .armed);

// file: sim/dcc_cpu_model.sv
`timescale 1ns/10ps
// ================
// cpu bus and queue model
module dcc_cpu_model (
    // clock
    input wire logic pclk,
    // monitored bus
    output dcc_pkg::dcc_access_t access,
    output logic [2:0] tag_exec
);
    initial access = '{1'b0, 1'b0, 1'b0, 16'h0000, 3'h0};
    initial tag_exec = 3'h0;
    task automatic put(logic [2:0] h, logic r, logic b, logic [15:0] d, logic [2:0] t);
        @(posedge pclk);
        access <= '{1'b1, r, b, d, h};
        tag_exec <= t;
    endtask
    // released bus shows inverted leftovers, never the last value
    task automatic idle();
        @(posedge pclk);
        access <= '{1'b0, ~access.read, ~access.byte_size, ~access.data, 3'h0};
        tag_exec <= 3'h0;
    endtask
endmodule // dcc_cpu_model

// file: sim/debug_comparator_control_test.sv
`timescale 1ns/10ps
module debug_comparator_control_test;
    localparam logic [11:0] UC = dcc_pkg::ADDR_UNIT_CTRL;
    localparam logic [11:0] CC = dcc_pkg::ADDR_COMP_CTRL;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, seq_session_end = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, breakpoint, trace_stop, armed, irq, r, b, e, t;
    logic [2:0] seq_trigger, opcode_tag, tag_exec;
    logic [7:0] c, ca, m [3] = '{dcc_pkg::MASK_COMP_A, dcc_pkg::MASK_COMP_B, dcc_pkg::MASK_COMP_C};
    logic [15:0] dv;
    dcc_pkg::dcc_access_t access;
    int err_total = 0, n_tests = 0, i;
    initial forever #5 pclk = ~pclk;
    dcc_top dcc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .access, .tag_exec, .seq_session_end, .seq_trigger, .opcode_tag,
        .breakpoint, .trace_stop, .armed, .irq);
    dcc_cpu_model dcc_cpu_model_inst (.pclk, .access, .tag_exec);
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic exp_trig(int k, logic [7:0] q, logic r, logic b, logic e, logic t);
        if (!q[0]) return 1'b0;
        if (q[5]) return t;
        if (q[7] && q[6] != b) return 1'b0;
        if (q[2] && q[3] != r) return 1'b0;
        return k != 0 || (e ^ q[1]);
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ================
    // main sequence
    initial begin
        void'($urandom(60));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 3; i++) begin
            c = $urandom | 8'hC2;
            if (i == 0) begin
                ca = c;
            end
            apb(1, UC, i);
            apb(1, CC, c);
            apb(0, CC, 0);
            chk(rd, c & m[i]);
        end
        apb(1, UC, 32'h80);
        apb(1, CC, 0);
        apb(0, CC, 0);
        chk(rd, ca);
        apb(0, 12'hFFC, 0);
        chk(rd, 0);
        $display("views and arming done");
        for (int n = 0; n < 80; n++) begin
            i = $urandom_range(2);
            c = $urandom & m[i];
            dv = $urandom;
            {r, b, e, t} = $urandom;
            apb(1, UC, i);
            apb(1, CC, c);
            apb(1, dcc_pkg::ADDR_COMP_DATA_A, dv);
            dcc_cpu_model_inst.put(3'h1 << i, r, b, e ? dv : ~dv, {3{t}});
            #1;
            chk(seq_trigger[i], exp_trig(i, c, r, b, e, t));
            chk(opcode_tag[i], c[0] & c[5]);
            dcc_cpu_model_inst.idle();
        end
        $display("matching done");
        for (int k = 0; k < 3; k++) begin
            apb(1, UC, 2);
            apb(1, CC, k < 2 ? 8'h11 : 8'h01);
            apb(1, UC, k == 1 ? 32'h82 : 32'h92);
            dcc_cpu_model_inst.put(3'h4, 1, 0, 16'h0000, 3'h0);
            #1;
            chk({breakpoint, trace_stop}, k == 0 ? 3 : k == 1 ? 1 : 0);
            dcc_cpu_model_inst.idle();
            #1;
            chk(armed, k == 2);
        end
        @(posedge pclk);
        seq_session_end <= 1'b1;
        @(posedge pclk);
        seq_session_end <= 1'b0;
        #1;
        chk(armed, 0);
        apb(0, dcc_pkg::ADDR_STATUS, 0);
        chk({rd[3], irq}, 2);
        apb(1, dcc_pkg::ADDR_INT_ENABLE, 8);
        #1;
        chk(irq, 1);
        apb(1, dcc_pkg::ADDR_INT_CLEAR, 8);
        apb(0, dcc_pkg::ADDR_STATUS, 0);
        chk({rd[3], irq}, 0);
        $display("session end done");
        final_report();
    end
    // run needs about a thousand cycles
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule // debug_comparator_control_test
